// ### src/ssc_ctrl.sv
/*
 * Sequence control for one serial bus channel: control and status registers
 * on a parallel host bus, start/stop/loop sequencing, trigger input, and a
 * data FIFO towards the bit-level engine.
 * Assumes host bus and engine run on i_clk; only i_trigger is asynchronous.
 */
// Function
// - Trigger enable frozen while channel is active
// - Trigger mode: go arms, each tick starts
// - Trigger input ignored when trigger disabled
// - Byte-count pointer clear, reads as zero
// - Table pointers clear, data pointer reloaded
// - Trigger coincident with go is ignored
// - Halt writes ignored while go is clear
// - Halt now beats halt after frame
// - Idle single mode: go starts sequence
// - Go writes ignored during single sequence
// - Single halt: stop after byte, done
// - Interval idle/trigger active halt: immediate inactive
// - Halt after frame: stop at frame end
// - Halt now: stop after byte, both flags
// - Edge select picks falling or rising
// - Stop seen on bus clears halt now
// - Go cleared when sequence or loop ends
// - Loop idle spans stop to next start
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_ctrl #(
	parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_b,
	input  wire logic [7:0]          i_addr,
	input  wire ssc_pkg::ssc_byte_t  i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output ssc_pkg::ssc_byte_t       o_rdata,
	input  wire logic [7:0]          i_loop_repeat_count,
	input  wire logic                i_trigger,
	input  wire logic                i_interval_tick,
	input  wire logic                i_frame_done,
	input  wire logic                i_stop_seen,
	output logic                     o_start_req,
	output logic                     o_halt_now,
	output logic                     o_halt_after_frame,
	output logic                     o_abort,
	output logic                     o_bytes_update,
	output logic                     o_byte_ptr_clr,
	output logic                     o_tbl_ptr_clr,
	output logic                     o_data_ptr_load,
	output logic                     o_active,
	input  wire ssc_pkg::ssc_byte_t  i_in_data,
	input  wire logic                i_in_valid,
	output logic                     o_in_ready,
	output ssc_pkg::ssc_byte_t       o_out_data,
	output logic                     o_out_valid,
	input  wire logic                i_out_ready
);
	import ssc_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	ssc_state_e state_reg;
	logic       go_reg;
	logic       halt_now_reg;
	logic       halt_frame_reg;
	logic       edge_sel_reg;
	logic       trig_en_reg;
	logic       seq_done_reg;
	logic       loop_done_reg;
	logic [7:0] frames_reg;
	logic       trig_s1_reg;
	logic       trig_s2_reg;
	logic       trig_s3_reg;
	logic       armed_reg;
	logic       ctl_wr;
	logic       sts_rd;
	logic       halt_ok;
	logic       req_now;
	logic       req_frame;
	logic       single_mode;
	logic       trig_tick;
	logic       fin_seq;
	logic       fin_loop;
	logic       fin_cut;
	logic       fifo_valid;
	ssc_byte_t  fifo_data;

	// Register decode, shared by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign ctl_wr      = i_wr & hit(i_addr, `SSC_OFS_CONTROL);
	assign sts_rd      = i_rd & hit(i_addr, `SSC_OFS_STATUS);
	assign single_mode = !trig_en_reg && (i_loop_repeat_count == `SSC_LOOP_SINGLE);

	// Halt requests only count while a sequence is running
	assign halt_ok   = ctl_wr & go_reg;
	assign req_now   = halt_ok & i_wdata[`SSC_CTL_HALT_NOW];
	assign req_frame = halt_ok & i_wdata[`SSC_CTL_HALT_FRAME] & !req_now;

	// ------------------------------------------------------------------
	// Trigger input: two-stage synchroniser, then edge detect
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else begin
			trig_s1_reg <= i_trigger;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	// One tick per qualifying edge; disabled trigger never ticks
	assign trig_tick = trig_en_reg & armed_reg &
		(edge_sel_reg ? (trig_s3_reg & !trig_s2_reg)
		              : (!trig_s3_reg & trig_s2_reg));

	// Arming lags go by one cycle, so a tick in the go cycle is lost
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			armed_reg <= 1'b0;
		end else begin
			armed_reg <= go_reg & (state_reg != SSC_IDLE);
		end
	end

	// ------------------------------------------------------------------
	// Completion events from the engine and from halts
	// ------------------------------------------------------------------
	// Natural end of a sequence, STOP already issued by the engine
	assign fin_seq = (state_reg == SSC_ACTIVE) & i_frame_done;
	// Loop ends after the counted frames, or on a pending frame halt
	assign fin_loop = fin_seq & (single_mode ? 1'b0 :
		(halt_frame_reg |
		 (!trig_en_reg && i_loop_repeat_count != 8'h00 &&
		  frames_reg + 8'h01 == i_loop_repeat_count)));
	// A halt-now cut reaches its STOP
	assign fin_cut = halt_now_reg & i_stop_seen &
		((state_reg == SSC_ACTIVE) | (state_reg == SSC_HALTING));

	// ------------------------------------------------------------------
	// Channel state and go flag
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg  <= SSC_IDLE;
			go_reg     <= 1'b0;
			frames_reg <= `SSC_RST_BYTE;
		end else begin
			unique case (state_reg)
				SSC_IDLE: begin
					// Go taken only here; a zero write does nothing
					if (ctl_wr && i_wdata[`SSC_CTL_GO]) begin
						go_reg     <= 1'b1;
						frames_reg <= `SSC_RST_BYTE;
						// Trigger mode waits for a tick instead of starting
						state_reg  <= i_wdata[`SSC_CTL_TRIG_EN] ? SSC_LOOP_IDLE
						                                       : SSC_ACTIVE;
					end
				end
				SSC_ACTIVE: begin
					// Go writes fall through untouched here
					// Trigger loop halts leave at once, ahead of a frame end
					if (trig_en_reg &&
					    (req_now || (halt_ok && i_wdata[`SSC_CTL_HALT_FRAME]))) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end else if (fin_cut) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end else if (fin_seq && single_mode) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end else if (fin_loop) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end else if (fin_seq) begin
						state_reg  <= SSC_LOOP_IDLE;
						frames_reg <= frames_reg + 8'h01;
					end
				end
				SSC_LOOP_IDLE: begin
					if (!trig_en_reg && (req_now || req_frame)) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end else if (trig_en_reg && (req_now || req_frame)) begin
						state_reg <= SSC_HALTING;
					end else if (trig_tick || (!trig_en_reg && i_interval_tick)) begin
						state_reg <= SSC_ACTIVE;
					end
				end
				SSC_HALTING: begin
					// Wait for the engine to put STOP on the bus
					if (i_stop_seen) begin
						state_reg <= SSC_IDLE;
						go_reg    <= 1'b0;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Halt flags; STOP seen on the bus clears halt now
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			halt_now_reg   <= 1'b0;
			halt_frame_reg <= 1'b0;
		end else begin
			if (req_now) begin
				halt_now_reg <= 1'b1;
			end else if (i_stop_seen) begin
				halt_now_reg <= 1'b0;
			end
			if (req_frame) begin
				halt_frame_reg <= 1'b1;
			end else if (state_reg == SSC_IDLE) begin
				halt_frame_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Trigger configuration, frozen outside idle
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trig_en_reg  <= 1'b0;
			edge_sel_reg <= 1'b0;
		end else if (ctl_wr && state_reg == SSC_IDLE) begin
			trig_en_reg  <= i_wdata[`SSC_CTL_TRIG_EN];
			edge_sel_reg <= i_wdata[`SSC_CTL_EDGE_SEL];
		end
	end

	// ------------------------------------------------------------------
	// Completion flags; a new event beats the clearing read
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			seq_done_reg  <= 1'b0;
			loop_done_reg <= 1'b0;
		end else begin
			if (fin_seq || fin_cut) begin
				seq_done_reg <= 1'b1;
			end else if (o_abort_next()) begin
				seq_done_reg <= 1'b1;
			end else if (sts_rd) begin
				seq_done_reg <= 1'b0;
			end
			if (fin_loop || o_abort_next() || (fin_cut && !single_mode)) begin
				loop_done_reg <= 1'b1;
			end else if (sts_rd) begin
				loop_done_reg <= 1'b0;
			end
		end
	end

	// Immediate inactive cases, and the end of a trigger-idle halt
	function automatic logic o_abort_next();
		return ((state_reg == SSC_LOOP_IDLE) && !trig_en_reg && (req_now || req_frame)) ||
		       ((state_reg == SSC_ACTIVE) && trig_en_reg &&
		        (req_now || (halt_ok && i_wdata[`SSC_CTL_HALT_FRAME]))) ||
		       ((state_reg == SSC_HALTING) && i_stop_seen);
	endfunction

	// ------------------------------------------------------------------
	// Engine strobes, all registered
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_start_req     <= 1'b0;
			o_abort         <= 1'b0;
			o_bytes_update  <= 1'b0;
			o_byte_ptr_clr  <= 1'b0;
			o_tbl_ptr_clr   <= 1'b0;
			o_data_ptr_load <= 1'b0;
		end else begin
			o_start_req <= (state_reg == SSC_IDLE && ctl_wr && i_wdata[`SSC_CTL_GO] &&
			                !i_wdata[`SSC_CTL_TRIG_EN]) ||
			               (state_reg == SSC_LOOP_IDLE && !req_now && !req_frame &&
			                (trig_tick || (!trig_en_reg && i_interval_tick)));
			o_abort         <= o_abort_next() && state_reg != SSC_HALTING;
			o_bytes_update  <= fin_cut;
			o_byte_ptr_clr  <= ctl_wr & i_wdata[`SSC_CTL_BYTE_CLR];
			o_tbl_ptr_clr   <= ctl_wr & i_wdata[`SSC_CTL_TBL_CLR];
			o_data_ptr_load <= ctl_wr & i_wdata[`SSC_CTL_TBL_CLR];
		end
	end

	// Mirror halt requests and activity to the engine
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_halt_now         <= 1'b0;
			o_halt_after_frame <= 1'b0;
			o_active           <= 1'b0;
		end else begin
			o_halt_now         <= req_now | (halt_now_reg & !i_stop_seen);
			o_halt_after_frame <= req_frame | (halt_frame_reg & state_reg != SSC_IDLE);
			o_active           <= state_reg == SSC_ACTIVE;
		end
	end

	// ------------------------------------------------------------------
	// Read path; clear strobes and the reserved bit read as zero
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= `SSC_RST_BYTE;
		end else if (i_rd) begin
			o_rdata <= `SSC_RST_BYTE;
			if (hit(i_addr, `SSC_OFS_CONTROL)) begin
				o_rdata[`SSC_CTL_HALT_FRAME] <= halt_frame_reg;
				o_rdata[`SSC_CTL_GO]         <= go_reg;
				o_rdata[`SSC_CTL_HALT_NOW]   <= halt_now_reg;
				o_rdata[`SSC_CTL_EDGE_SEL]   <= edge_sel_reg;
				o_rdata[`SSC_CTL_TRIG_EN]    <= trig_en_reg;
			end else if (hit(i_addr, `SSC_OFS_STATUS)) begin
				o_rdata[`SSC_STS_SEQ_DONE]  <= seq_done_reg;
				o_rdata[`SSC_STS_LOOP_DONE] <= loop_done_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// Sequence data FIFO; head word registered towards the engine
	// ------------------------------------------------------------------
	ssc_fifo #(
		.WIDTH (`SSC_DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_data   (i_in_data),
		.i_in_valid  (i_in_valid),
		.o_in_ready  (o_in_ready),
		.o_out_data  (fifo_data),
		.o_out_valid (fifo_valid),
		.i_out_ready (i_out_ready & o_out_valid)
	);

	// Output word is a flop copy of the head; popped only when shown
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_out_data  <= `SSC_RST_BYTE;
			o_out_valid <= 1'b0;
		end else begin
			o_out_data  <= fifo_data;
			o_out_valid <= fifo_valid && !(i_out_ready && o_out_valid);
		end
	end

endmodule // ssc_ctrl

// ### src/ssc_defs.svh
/*
 * Offsets, field positions, reset values and counts of the serial sequence
 * control block. Assumes inclusion by bare name from the control module; the package does not include it.
 */
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the parallel bus
// ----------------------------------------------------------------------
`define SSC_OFS_CONTROL     8'he0
`define SSC_OFS_STATUS      8'he1

// ----------------------------------------------------------------------
// Channel control fields
// ----------------------------------------------------------------------
`define SSC_CTL_HALT_FRAME  7
`define SSC_CTL_GO          6
`define SSC_CTL_HALT_NOW    5
`define SSC_CTL_EDGE_SEL    4
`define SSC_CTL_TRIG_EN     3
`define SSC_CTL_BYTE_CLR    2
`define SSC_CTL_TBL_CLR     1

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define SSC_STS_SEQ_DONE    7
`define SSC_STS_LOOP_DONE   6

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SSC_RST_BYTE        8'h00
`define SSC_LOOP_SINGLE     8'h01
`define SSC_FIFO_DEPTH      16
`define SSC_DATA_W          8

`endif

// ### src/ssc_pkg.sv
/*
 * Types of the serial sequence control block.
 * Needs nothing from ssc_defs.svh; only ssc_ctrl includes it.
 */
package ssc_pkg;

	// ------------------------------------------------------------------
	// Channel states, Gray coded along idle, active, loop idle, halting
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SSC_IDLE      = 2'b00,
		SSC_ACTIVE    = 2'b01,
		SSC_LOOP_IDLE = 2'b11,
		SSC_HALTING   = 2'b10
	} ssc_state_e;

	typedef logic [7:0] ssc_byte_t;

endpackage : ssc_pkg

// ### src/ssc_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and registered flags.
 * Assumes both sides run on i_clk.
 */
`timescale 1ns/100ps
module ssc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_in_data,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	output logic [WIDTH-1:0]      o_out_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Flags are registered so neither side sees a combinational path
	assign push = i_in_valid & o_in_ready;
	assign pop  = o_out_valid & i_out_ready;

	// ------------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_reg  <= '0;
			rd_ptr_reg  <= '0;
			count_reg   <= '0;
			o_in_ready  <= 1'b0;
			o_out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg   <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
			o_in_ready  <= (count_reg + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
			o_out_valid <= (count_reg + (AW+1)'(push) - (AW+1)'(pop)) != '0;
		end
	end

	// Head word; stable while valid holds and no pop
	assign o_out_data = mem[rd_ptr_reg];

endmodule // ssc_fifo

// ### verification/ssc_ctrl_properties.sv
/* Port checker for ssc_ctrl, bound to every instance.
   Assumes ssc_pkg is compiled first. */
`timescale 1ns/100ps
module ssc_ctrl_properties (
	input wire logic               i_clk,
	input wire logic               i_rst_b,
	input wire logic [7:0]         i_addr,
	input wire ssc_pkg::ssc_byte_t i_wdata,
	input wire logic               i_wr,
	input wire logic               i_rd,
	input wire ssc_pkg::ssc_byte_t o_rdata,
	input wire logic               i_stop_seen,
	input wire logic               o_start_req,
	input wire logic               o_halt_now,
	input wire logic               o_abort,
	input wire logic               o_bytes_update,
	input wire logic               o_byte_ptr_clr,
	input wire logic               o_tbl_ptr_clr,
	input wire logic               o_data_ptr_load,
	input wire logic               o_active
);
	import ssc_pkg::*;
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_ctl_low_zero: assert property (i_rd && i_addr == 8'he0 |=> o_rdata[2:0] == 3'h0)
		else $error("control low bits not zero");
	a_byte_clr_pulse: assert property (o_byte_ptr_clr == $past(i_wr && i_addr == 8'he0 && i_wdata[2]))
		else $error("byte pointer clear mismatch");
	a_tbl_clr_pulse: assert property (i_wr && i_addr == 8'he0 && i_wdata[1] |=> o_tbl_ptr_clr)
		else $error("table clear missing");
	a_data_ptr_pair: assert property (o_tbl_ptr_clr == o_data_ptr_load)
		else $error("data pointer load not paired");
	a_stop_frees_halt: assert property (i_stop_seen && !i_wr |=> !o_halt_now)
		else $error("halt now not cleared by stop");
	a_abort_goes_idle: assert property (o_abort |-> ##[0:2] !o_active)
		else $error("abort left channel active");
	a_start_goes_active: assert property (o_start_req |-> ##[1:2] o_active)
		else $error("start without activity");
	a_update_after_stop: assert property (o_bytes_update |-> $past(i_stop_seen) || $past(i_stop_seen, 2))
		else $error("byte update without stop");
	a_start_one_cycle: assert property (o_start_req |=> !o_start_req)
		else $error("start longer than one cycle");
endmodule // ssc_ctrl_properties

bind ssc_ctrl ssc_ctrl_properties u_props (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_stop_seen, .o_start_req, .o_halt_now, .o_abort, .o_bytes_update,
	.o_byte_ptr_clr, .o_tbl_ptr_clr, .o_data_ptr_load, .o_active);

// ### verification/ssc_engine_model.sv
/* Far-side model: bit engine and bus targets, plus FIFO drain.
   Assumes it runs on the same clock as ssc_ctrl. */
`timescale 1ns/100ps
module ssc_engine_model (
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       i_start_req,
	input wire logic       i_halt_now,
	input wire logic       i_halt_after_frame,
	input wire logic       i_abort,
	input wire logic [7:0] i_frame_len,
	input wire logic       i_stall,
	output logic           o_frame_done,
	output logic           o_stop_seen,
	output logic           o_out_ready
);
	logic [7:0] cnt;
	logic       busy;
	logic       sent;
	// Frame timing; STOP at every frame end, plus one per halt request while not busy
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{cnt, busy, sent, o_frame_done, o_stop_seen} <= '0;
		end else begin
			o_frame_done <= 1'b0;
			o_stop_seen <= 1'b0;
			if (!i_halt_now && !i_halt_after_frame)
				sent <= 1'b0;
			if (i_start_req) begin
				busy <= 1'b1;
				cnt <= i_frame_len;
			end else if (i_abort) begin
				busy <= 1'b0;
			end else if (busy && i_halt_now && !sent && cnt > 8'h03) begin
				cnt <= 8'h03;
			end else if (busy && cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end else if (busy) begin
				busy <= 1'b0;
				o_stop_seen <= 1'b1;
				o_frame_done <= !i_halt_now;
				sent <= i_halt_now | i_halt_after_frame;
			end else if ((i_halt_now || i_halt_after_frame) && !sent) begin
				o_stop_seen <= 1'b1;
				sent <= 1'b1;
			end
		end
	end
	// Drain takes every other cycle so the FIFO sees stalls too
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_out_ready <= 1'b0;
		else
			o_out_ready <= !i_stall && !o_out_ready;
	end
endmodule // ssc_engine_model

// ### verification/tb.sv
/* Self-checking bench for ssc_ctrl with the engine model.
   Assumes design, package and checker are compiled first. */
`timescale 1ns/100ps
module tb;
	import ssc_pkg::*;
	logic       i_clk, i_rst_b, i_wr, i_rd, i_trigger, i_interval_tick, i_in_valid, stall;
	logic [7:0] i_addr, i_loop_repeat_count, flen;
	ssc_byte_t  i_wdata, i_in_data, o_rdata, o_out_data;
	logic       frame_done, stop_seen, out_ready, o_start_req, o_halt_now, o_halt_after_frame;
	logic       o_abort, o_bytes_update, o_active, o_in_ready, o_out_valid;
	logic [7:0] q[$];
	integer     seed;
	int         ev[4], mk[4], n_errors, tests_run;

	ssc_ctrl #(.FIFO_DEPTH(16)) u_dut (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_loop_repeat_count, .i_trigger, .i_interval_tick,
		.i_frame_done(frame_done), .i_stop_seen(stop_seen), .o_start_req, .o_halt_now,
		.o_halt_after_frame, .o_abort, .o_bytes_update, .o_byte_ptr_clr(), .o_tbl_ptr_clr(),
		.o_data_ptr_load(), .o_active, .i_in_data, .i_in_valid, .o_in_ready, .o_out_data,
		.o_out_valid, .i_out_ready(out_ready));
	ssc_engine_model u_eng (.i_clk, .i_rst_b, .i_start_req(o_start_req), .i_halt_now(o_halt_now),
		.i_halt_after_frame(o_halt_after_frame), .i_abort(o_abort), .i_frame_len(flen),
		.i_stall(stall), .o_frame_done(frame_done), .o_stop_seen(stop_seen),
		.o_out_ready(out_ready));

	// ----------------------------------------------------------------
	// Clock, event counters, watchdog
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Pulses are counted so scenarios never race a one-cycle output
	always @(posedge i_clk) begin
		ev[0] += o_start_req;
		ev[1] += o_abort;
		ev[2] += o_bytes_update;
		ev[3] += stop_seen;
	end
	initial begin
		#300000;
		n_errors++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Tasks and expectations
	// ----------------------------------------------------------------
	function automatic logic [7:0] sts(input logic sd, input logic loop_finished_flag);
		return {sd, loop_finished_flag, 6'h00};
	endfunction
	function automatic logic [7:0] ctl(input logic go, input logic te, input logic tp);
		return {1'b0, go, 1'b0, tp, te, 3'h0};
	endfunction
	task automatic close_out();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1 {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
		@(posedge i_clk) #1 i_wr = 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk) #1 {i_addr, i_rd} = {a, 1'b1};
		@(posedge i_clk) #1 i_rd = 1'b0;
		chk(nm, e, o_rdata);
	endtask
	task automatic done_chk(input logic [7:0] es, input logic [7:0] ec);
		rd_chk("status", 8'he1, es);
		rd_chk("control", 8'he0, ec);
	endtask
	// Marks the counters and draws a fresh frame length
	task automatic snap();
		mk = ev;
		flen = 8'h14 + 8'({$random(seed)} % 20);
	endtask
	task automatic wait_ev(input int k);
		int t;
		t = 0;
		while (ev[k] <= mk[k] && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		chk("event seen", 8'h01, 8'(ev[k] > mk[k]));
	endtask
	task automatic trig(input logic v);
		repeat (4) @(posedge i_clk);
		#1 i_trigger = v;
		#40;
	endtask
	task automatic tick();
		@(posedge i_clk) #1 i_interval_tick = 1'b1;
		@(posedge i_clk) #1 i_interval_tick = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h547a5602;
		{i_wr, i_rd, i_trigger, i_interval_tick, i_in_valid, stall, i_rst_b} = '0;
		{i_addr, i_wdata, i_in_data, flen} = '0;
		i_loop_repeat_count = 8'h01;
		repeat (5) @(posedge i_clk);
		#1 i_rst_b = 1'b1;
		rd_chk("control reset", 8'he0, 8'h00);
		rd_chk("status reset", 8'he1, 8'h00);
		rd_chk("unmapped read", 8'h5a, 8'h00);
		wr(8'h5a, 8'h48);
		wr(8'he0, 8'h06);
		wr(8'he0, 8'ha0);
		rd_chk("control idle", 8'he0, 8'h00);
		chk("starts", 8'h00, 8'(ev[0]));
		// Single sequence with a zero control write while it runs
		snap();
		wr(8'he0, 8'h40);
		wait_ev(0);
		wr(8'he0, 8'h00);
		rd_chk("go held", 8'he0, ctl(1, 0, 0));
		wait_ev(3);
		done_chk(sts(1, 0), ctl(0, 0, 0));
		rd_chk("status cleared", 8'he1, 8'h00);
		snap();
		wr(8'he0, 8'h40);
		wait_ev(0);
		wr(8'he0, 8'h60);
		wait_ev(2);
		done_chk(sts(1, 0), ctl(0, 0, 0));
		// Interval loop of two frames
		i_loop_repeat_count = 8'h02;
		snap();
		wr(8'he0, 8'h40);
		wait_ev(3);
		rd_chk("loop idle go", 8'he0, ctl(1, 0, 0));
		snap();
		tick();
		wait_ev(0);
		wait_ev(3);
		done_chk(sts(1, 1), ctl(0, 0, 0));
		// Loop idle: stray trigger, then halt
		i_loop_repeat_count = 8'h03;
		snap();
		wr(8'he0, 8'h40);
		wait_ev(3);
		snap();
		trig(1'b1);
		trig(1'b0);
		repeat (10) @(negedge i_clk);
		chk("starts", 8'(mk[0]), 8'(ev[0]));
		wr(8'he0, 8'hc0);
		wait_ev(1);
		done_chk(sts(1, 1), ctl(0, 0, 0));
		// Endless loop: both halts, then halt after frame
		i_loop_repeat_count = 8'h00;
		snap();
		wr(8'he0, 8'h40);
		wait_ev(0);
		wr(8'he0, 8'he0);
		wait_ev(2);
		done_chk(sts(1, 1), ctl(0, 0, 0));
		snap();
		wr(8'he0, 8'h40);
		wait_ev(0);
		wr(8'he0, 8'hc0);
		wait_ev(3);
		done_chk(sts(1, 1), ctl(0, 0, 0));
		chk("aborts", 8'(mk[1]), 8'(ev[1]));
		// Trigger loop on rising edges
		i_loop_repeat_count = 8'h01;
		wr(8'he0, 8'h08);
		snap();
		@(posedge i_clk) #1 i_trigger = 1'b1;
		wr(8'he0, 8'h48);
		repeat (20) @(negedge i_clk);
		chk("starts", 8'(mk[0]), 8'(ev[0]));
		trig(1'b0);
		trig(1'b1);
		wait_ev(0);
		wr(8'he0, 8'h40);
		rd_chk("enable frozen", 8'he0, ctl(1, 1, 0));
		wait_ev(3);
		trig(1'b0);
		repeat (20) @(negedge i_clk);
		chk("starts", 8'(mk[0] + 1), 8'(ev[0]));
		rd_chk("trigger go", 8'he0, ctl(1, 1, 0));
		snap();
		trig(1'b1);
		wait_ev(0);
		wr(8'he0, 8'hc8);
		wait_ev(1);
		done_chk(sts(1, 1), ctl(0, 1, 0));
		// Falling edge trigger, halt from trigger loop idle
		wr(8'he0, 8'h18);
		wr(8'he0, 8'h58);
		snap();
		trig(1'b0);
		wait_ev(0);
		wait_ev(3);
		snap();
		wr(8'he0, 8'h78);
		wait_ev(3);
		done_chk(sts(1, 1), ctl(0, 1, 1));
		// Trigger loop idle: halt after frame waits for the STOP
		wr(8'he0, 8'h58);
		snap();
		trig(1'b1);
		trig(1'b0);
		wait_ev(0);
		wait_ev(3);
		snap();
		wr(8'he0, 8'hd8);
		wait_ev(3);
		done_chk(sts(1, 1), ctl(0, 1, 1));
		chk("aborts", 8'(mk[1]), 8'(ev[1]));
		// FIFO filled against a stalled drain, then emptied
		stall = 1'b1;
		@(posedge i_clk) #1 {i_in_data, i_in_valid} = {8'($random(seed)), 1'b1};
		repeat (40) begin
			@(negedge i_clk);
			if (o_in_ready) begin
				q.push_back(i_in_data);
				@(posedge i_clk) #1 i_in_data = 8'($random(seed));
			end
		end
		@(posedge i_clk) #1 {i_in_valid, stall} = 2'b00;
		chk("fifo fill", 8'd16, 8'(q.size()));
		repeat (100) begin
			@(negedge i_clk);
			if (o_out_valid && out_ready && q.size() > 0)
				chk("fifo word", q.pop_front(), o_out_data);
		end
		chk("fifo left", 8'h00, 8'(q.size()));
		close_out();
	end
endmodule // tb
